// *** core/prb_pkg.sv ***
// Package for the peripheral register access bridge
package prb_pkg;

    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;

    // Address windows (upper bits compared against these bases)
    localparam logic [31:0] SYS_BASE   = 32'h0008_0000;
    localparam logic [31:0] SYS_MASK   = 32'hFFFF_FC00;
    localparam logic [31:0] BUS_BASE   = 32'h0008_1300;
    localparam logic [31:0] BERR_MASK  = 32'hFFFF_FFF0;
    localparam logic [31:0] BUS_MASK   = 32'hFFFF_FF00;
    localparam logic [31:0] XFER_BASE  = 32'h0008_2400;
    localparam logic [31:0] INTR_BASE  = 32'h0008_7000;
    localparam logic [31:0] INTR_MASK  = 32'hFFFF_F000;
    localparam logic [31:0] XBUS_BASE  = 32'h0008_1400;

    // Core clock cycle counts
    localparam logic [3:0] SYS_CYCLES  = 4'h3;
    localparam logic [3:0] FAST_CYCLES = 4'h2;
    localparam logic [3:0] MAIN_CYCLES = 4'h1;

    // Peripheral bus number field position within the address
    localparam int PBUS_LSB = 16;
    localparam logic [2:0] PBUS_ONE = 3'h1;

    typedef enum logic [1:0] {
        PRB_CLS_SYS,
        PRB_CLS_FAST,
        PRB_CLS_PBUS1,
        PRB_CLS_SYNC
    } prb_cls_t;

    typedef struct packed {
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } prb_req_t;

    typedef struct packed {
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [2:0]        bus;
    } prb_preq_t;

endpackage

// *** core/prb_bridge.sv ***
// CPU to peripheral bus bridge with access cycle timing
//
// Behaviour
// RULE_01 - Access cycles: main, sync, peripheral cycles summed
// RULE_02 - Peripheral cycles set per register by slave
// RULE_03 - Sync added for buses 2-6, not bus-error
// RULE_04 - Sync length follows clock ratio and phase
// RULE_05 - Fast core: main plus sync within one period
// RULE_06 - Slow core: next access on following core cycle
// RULE_07 - Counts hold only without transfer controller contention
// RULE_08 - Software avoids system writes during sleep
// RULE_09 - Software reads back last written register
// RULE_10 - System control registers take three core cycles
// RULE_11 - Bus, transfer, interrupt registers take two cycles
// RULE_12 - CPU stalled until peripheral side completes
`timescale 1ns/1ns
module prb_bridge
    import prb_pkg::*;
(
    input  wire logic                core_clk,
    input  wire logic                reset,
    // CPU side
    input  wire logic                cpu_valid,
    input  wire prb_req_t            cpu_req,
    output logic                     cpu_ready,
    output logic [DATA_W-1:0]        cpu_rdata,
    // Competing bus master
    input  wire logic                xfer_busy,
    // Divided clock edge marker (pin domain)
    input  wire logic                pclk_edge,
    input  wire logic                core_ge_pclk,
    // Local register slaves (system, bus, transfer, interrupt)
    output logic                     loc_sel,
    output prb_req_t                 loc_req,
    input  wire logic [DATA_W-1:0]   loc_rdata,
    // Peripheral buses 0 to 7
    output logic                     per_valid,
    output prb_preq_t                per_req,
    input  wire logic                per_done,
    input  wire logic [DATA_W-1:0]   per_rdata
);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LOCAL,
        ST_SYNC,
        ST_PER,
        ST_DONE
    } prb_state_t;

    prb_state_t        state_ff, nxt_state;
    prb_req_t          req_ff, nxt_req;
    logic [3:0]        cnt_ff, nxt_cnt;
    logic [DATA_W-1:0] rdata_ff, nxt_rdata;
    logic [2:0]        bus_ff, nxt_bus;
    logic              edge_s1_ff, edge_s2_ff, edge_s3_ff;
    logic              ratio_s1_ff, ratio_s2_ff;
    logic              edge_rise;
    prb_cls_t          cls_dec;
    logic [2:0]        bus_dec;

    // Two-flop synchronisers for the divided-clock marker and ratio strap
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            edge_s1_ff  <= 1'b0;
            edge_s2_ff  <= 1'b0;
            edge_s3_ff  <= 1'b0;
            ratio_s1_ff <= 1'b0;
            ratio_s2_ff <= 1'b0;
        end else begin
            edge_s1_ff  <= pclk_edge;
            edge_s2_ff  <= edge_s1_ff;
            edge_s3_ff  <= edge_s2_ff;
            ratio_s1_ff <= core_ge_pclk;
            ratio_s2_ff <= ratio_s1_ff;
        end
    end
    assign edge_rise = edge_s2_ff & ~edge_s3_ff;

    // Address class decode
    always_comb begin
        bus_dec = cpu_req.addr[PBUS_LSB +: 3];
        if ((cpu_req.addr & SYS_MASK) == SYS_BASE) begin
            cls_dec = PRB_CLS_SYS;                                 // [RULE_10]
        // Whole bus controller window is fast, bus-error registers included
        end else if (((cpu_req.addr & BUS_MASK) == BUS_BASE) ||
                     ((cpu_req.addr & BUS_MASK) == XFER_BASE) ||
                     ((cpu_req.addr & INTR_MASK) == INTR_BASE)) begin
            cls_dec = PRB_CLS_FAST;                                // [RULE_11] [RULE_03]
        end else if ((cpu_req.addr & BUS_MASK) == XBUS_BASE) begin
            cls_dec = PRB_CLS_SYNC;                                // [RULE_03]
        end else if (bus_dec == PBUS_ONE) begin
            cls_dec = PRB_CLS_PBUS1;                               // [RULE_03]
        end else begin
            cls_dec = PRB_CLS_SYNC;                                // [RULE_03]
        end
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_req   = req_ff;
        nxt_cnt   = cnt_ff;
        nxt_rdata = rdata_ff;
        nxt_bus   = bus_ff;
        case (state_ff)
            ST_IDLE: begin
                // Contention with the transfer controller delays the start
                if (cpu_valid && !xfer_busy) begin                 // [RULE_07]
                    nxt_req = cpu_req;
                    nxt_bus = bus_dec;
                    if (cls_dec == PRB_CLS_SYS) begin
                        nxt_cnt   = SYS_CYCLES - MAIN_CYCLES;      // [RULE_10] [RULE_01]
                        nxt_state = ST_LOCAL;
                    end else if (cls_dec == PRB_CLS_FAST) begin
                        nxt_cnt   = FAST_CYCLES - MAIN_CYCLES;     // [RULE_11] [RULE_01]
                        nxt_state = ST_LOCAL;
                    end else if (cls_dec == PRB_CLS_SYNC) begin
                        nxt_state = ST_SYNC;                       // [RULE_01]
                    end else begin
                        nxt_state = ST_PER;
                    end
                end
            end
            ST_LOCAL: begin
                if (cnt_ff == MAIN_CYCLES) begin
                    nxt_rdata = loc_rdata;
                    nxt_state = ST_DONE;
                end else begin
                    nxt_cnt = cnt_ff - MAIN_CYCLES;
                end
            end
            ST_SYNC: begin
                // Wait for the divided-clock edge; fast core waits at most one period
                if (edge_rise || !ratio_s2_ff) begin               // [RULE_04] [RULE_05]
                    nxt_state = ST_PER;
                end
            end
            ST_PER: begin
                // Slave decides its own length per register
                if (per_done) begin                                // [RULE_02]
                    nxt_rdata = per_rdata;
                    nxt_state = ST_DONE;
                end
            end
            ST_DONE: begin
                nxt_state = ST_IDLE;                               // [RULE_06]
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_ff <= ST_IDLE;
            req_ff   <= '0;
            cnt_ff   <= 4'h0;
            rdata_ff <= 32'h0000_0000;
            bus_ff   <= 3'h0;
        end else begin
            state_ff <= nxt_state;
            req_ff   <= nxt_req;
            cnt_ff   <= nxt_cnt;
            rdata_ff <= nxt_rdata;
            bus_ff   <= nxt_bus;
        end
    end

    assign cpu_ready     = (state_ff == ST_DONE);                  // [RULE_12]
    assign cpu_rdata     = rdata_ff;
    assign loc_sel       = (state_ff == ST_LOCAL);
    assign loc_req       = req_ff;
    assign per_valid     = (state_ff == ST_PER);
    assign per_req.wr    = req_ff.wr;
    assign per_req.addr  = req_ff.addr;
    assign per_req.wdata = req_ff.wdata;
    assign per_req.bus   = bus_ff;

    // Assertions
    sequence s_sys_start;
        state_ff == ST_IDLE && cpu_valid && !xfer_busy && cls_dec == PRB_CLS_SYS;
    endsequence
    sequence s_fast_start;
        state_ff == ST_IDLE && cpu_valid && !xfer_busy && cls_dec == PRB_CLS_FAST;
    endsequence

    a_sys_three_cycles: assert property (@(posedge core_clk) disable iff (reset) // [RULE_10]
        s_sys_start |-> !cpu_ready ##1 !cpu_ready ##1 !cpu_ready ##1 cpu_ready)
        else $error("system register access not three cycles");
    a_fast_two_cycles: assert property (@(posedge core_clk) disable iff (reset) // [RULE_11]
        s_fast_start |-> !cpu_ready ##1 !cpu_ready ##1 cpu_ready)
        else $error("fast register access not two cycles");
    a_xfer_holds_off: assert property (@(posedge core_clk) disable iff (reset) // [RULE_07]
        state_ff == ST_IDLE && xfer_busy |=> state_ff == ST_IDLE)
        else $error("access started during transfer controller contention");
    a_sync_added: assert property (@(posedge core_clk) disable iff (reset) // [RULE_03]
        state_ff == ST_IDLE && cpu_valid && !xfer_busy && cls_dec == PRB_CLS_SYNC
        |=> state_ff == ST_SYNC)
        else $error("sync cycles not added");
    a_sync_waits_edge: assert property (@(posedge core_clk) disable iff (reset) // [RULE_04]
        state_ff == ST_SYNC && ratio_s2_ff && !edge_rise |=> state_ff == ST_SYNC)
        else $error("sync left without divided clock edge");
    a_per_stall: assert property (@(posedge core_clk) disable iff (reset) // [RULE_12]
        per_valid && !per_done |=> !cpu_ready)
        else $error("cpu released before peripheral done");
    a_per_done_ready: assert property (@(posedge core_clk) disable iff (reset) // [RULE_02]
        per_valid && per_done |=> cpu_ready && cpu_rdata == $past(per_rdata))
        else $error("peripheral completion not returned");
    a_next_access: assert property (@(posedge core_clk) disable iff (reset) // [RULE_06]
        cpu_ready |=> state_ff == ST_IDLE ##0 !cpu_ready)
        else $error("bridge not free after completion");
    a_bus1_no_sync: assert property (@(posedge core_clk) disable iff (reset) // [RULE_01]
        state_ff == ST_IDLE && cpu_valid && !xfer_busy && cls_dec == PRB_CLS_PBUS1
        |=> per_valid)
        else $error("bus one access took sync cycles");
    a_berr_no_sync: assert property (@(posedge core_clk) disable iff (reset) // [RULE_03]
        state_ff == ST_IDLE && cpu_valid && !xfer_busy &&
        (cpu_req.addr & BERR_MASK) == BUS_BASE
        |=> loc_sel)
        else $error("bus error register access took sync cycles");

endmodule

// *** bench/prb_far_model.sv ***
// Far-side model: local register slaves and peripheral bus slave
`timescale 1ns/1ns
module prb_far_model
    import prb_pkg::*;
(
    input  wire logic          core_clk,
    input  wire logic          reset,
    input  wire logic          loc_sel,
    input  wire prb_req_t      loc_req,
    output logic [DATA_W-1:0]  loc_rdata,
    input  wire logic          per_valid,
    input  wire prb_preq_t     per_req,
    output logic               per_done,
    output logic [DATA_W-1:0]  per_rdata
);
    logic [1:0]  wait_ff;
    logic [31:0] junk_ff;
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            wait_ff <= 2'h0;
            per_done <= 1'b0;
            junk_ff <= 32'hA5A5_0001;
        end else begin
            junk_ff <= ~junk_ff + 32'h0000_0001;
            // Wait set per register by address bits
            per_done <= per_valid && !per_done && (wait_ff == per_req.addr[3:2]);
            wait_ff <= (per_valid && !per_done) ? wait_ff + 2'h1 : 2'h0;
        end
    end
    // Undriven read data shows a changing pattern
    assign loc_rdata = loc_sel ? (loc_req.addr ^ 32'hC3C3_0000) : junk_ff;
    assign per_rdata = per_done ? (per_req.addr ^ 32'h5A5A_0000) : junk_ff;
endmodule

// *** bench/prb_bridge_tb.sv ***
// Self-checking testbench for the peripheral register access bridge
`timescale 1ns/1ns
module prb_bridge_tb
    import prb_pkg::*;
;
    logic core_clk, reset, cpu_valid, cpu_ready, xfer_busy, core_ge_pclk, pclk_run;
    logic loc_sel, per_valid, per_done;
    logic [2:0] div_cnt = 3'h0;
    logic [31:0] cpu_rdata, loc_rdata, per_rdata, rd;
    prb_req_t cpu_req, loc_req;
    prb_preq_t per_req;
    int err_count, total_checks, cyc, i;
    wire pclk_edge = div_cnt[2] & pclk_run;

    prb_bridge dut_u (.core_clk(core_clk), .reset(reset), .cpu_valid(cpu_valid),
        .cpu_req(cpu_req), .cpu_ready(cpu_ready), .cpu_rdata(cpu_rdata), .xfer_busy(xfer_busy),
        .pclk_edge(pclk_edge), .core_ge_pclk(core_ge_pclk), .loc_sel(loc_sel),
        .loc_req(loc_req), .loc_rdata(loc_rdata), .per_valid(per_valid),
        .per_req(per_req), .per_done(per_done), .per_rdata(per_rdata));
    prb_far_model far_u (.core_clk(core_clk), .reset(reset), .loc_sel(loc_sel),
        .loc_req(loc_req), .loc_rdata(loc_rdata), .per_valid(per_valid),
        .per_req(per_req), .per_done(per_done), .per_rdata(per_rdata));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // Divided clock marker, period of eight core cycles
    always @(negedge core_clk) div_cnt <= div_cnt + 3'h1;

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // One access; cycles counted from the request edge to the completion pulse
    task automatic access(input logic wr, input logic [31:0] addr, input int xfer_n);
        prb_preq_t pr;
        pr = '{wr, addr, addr ^ 32'h0F0F_0000, addr[18:16]};
        cyc = 0;
        cpu_req = '{wr, addr, pr.wdata};
        cpu_valid = 1'b1;
        xfer_busy = (xfer_n > 0);
        while (cpu_ready !== 1'b1) begin
            @(negedge core_clk);
            cyc++;
            if (cyc == xfer_n) xfer_busy = 1'b0;
            if (per_valid === 1'b1) check(per_req, pr);
            if (loc_sel === 1'b1) check(loc_req, cpu_req);
            if (cyc > 200) begin
                err_count++;
                $display("[ERR] %0t access timed out", $time);
                wrap_up();
            end
        end
        rd = cpu_rdata;
        @(negedge core_clk);
        cpu_valid = 1'b0;
        // One idle edge before the next request
        @(negedge core_clk);
    endtask

    task automatic t_local();
        logic [31:0] adr [6] = '{32'h0008_0020, 32'h0008_03FE, 32'h0008_1304,
                                 32'h0008_1310, 32'h0008_2404, 32'h0008_7010};
        for (i = 0; i < 12; i++) begin
            // Writes issued only in normal run mode
            access(i[0], adr[i/2], 0);
            check(cyc, (i < 4) ? 3 : 2);
            if (!i[0]) check(rd, adr[i/2] ^ 32'hC3C3_0000);
        end
        $display("test local done");
    endtask

    task automatic t_bus1();
        access(1'b1, 32'h0009_0000, 0);
        check(cyc, 3);
        access(1'b1, 32'h0009_000C, 0);
        check(cyc, 6);
        access(1'b0, 32'h0009_000C, 0); // Read back last written
        check(rd, 32'h5A53_000C);
        $display("test bus1 done");
    endtask

    task automatic t_sync();
        logic [31:0] adr [3] = '{32'h000A_0008, 32'h0008_1400, 32'h000E_0004};
        for (i = 0; i < 3; i++) begin
            access(1'b0, adr[i], 0);
            check(cyc >= 4 + adr[i][3:2] && cyc <= 11 + adr[i][3:2], 1);
            check(rd, adr[i] ^ 32'h5A5A_0000);
        end
        $display("test sync done");
    endtask

    task automatic t_slow();
        core_ge_pclk = 1'b0;
        pclk_run = 1'b0;
        repeat (5) @(negedge core_clk);
        access(1'b0, 32'h000A_0004, 0);
        check(cyc, 5);
        core_ge_pclk = 1'b1;
        pclk_run = 1'b1;
        $display("test slow done");
    endtask

    task automatic t_xfer();
        access(1'b0, 32'h0008_0000, 5);
        check(cyc, 8);
        access(1'b1, 32'h0009_0000, 4);
        check(cyc, 7);
        $display("test xfer done");
    endtask

    // Reset in the middle of a peripheral access
    task automatic t_reset();
        cpu_req = '{1'b0, 32'h0009_000C, 32'h0000_0000};
        cpu_valid = 1'b1;
        repeat (3) @(negedge core_clk);
        check(per_valid, 1'b1);
        reset = 1'b1;
        cpu_valid = 1'b0;
        @(negedge core_clk);
        check({cpu_ready, per_valid, loc_sel}, 3'h0);
        check(cpu_rdata, 32'h0000_0000);
        repeat (2) @(negedge core_clk);
        reset = 1'b0;
        @(negedge core_clk);
        access(1'b0, 32'h0008_0000, 0);
        check(cyc, 3);
        check(rd, 32'hC3CB_0000);
        $display("test reset done");
    endtask

    initial begin
        err_count = 0;
        total_checks = 0;
        reset = 1'b1;
        cpu_valid = 1'b0;
        cpu_req = '0;
        xfer_busy = 1'b0;
        core_ge_pclk = 1'b1;
        pclk_run = 1'b1;
        repeat (16) @(negedge core_clk);
        reset = 1'b0;
        t_local();
        t_bus1();
        t_sync();
        t_slow();
        t_xfer();
        t_reset();
        wrap_up();
    end
endmodule
